// ==== core/sbl_loader.sv ====
// Boot loader core: rate measurement, handshake, full erase, program load into RAM and jump.
// Also guards block erase and programming in user program mode.
// Assumes all pins synchronous to ref_clk and a flash controller that pulses flash_done.
`timescale 1ns/1ps
module sbl_loader import sbl_pkg::*; #(
	parameter int WAIT_CYC = START_WAIT_STATES
) (
	input wire logic ref_clk, // 25 MHz system clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic boot_strap, // Mode pins select boot mode
	input wire logic flash_write_enable_pin, // Write enable pin level
	input wire logic sw_pin_ok, // Software has confirmed the pin level
	input wire logic rxd, // Serial channel 1 receive
	input wire logic flash_done, // Flash controller finished an erase or program
	input wire logic blk_erase_req, // User mode block erase request
	input wire logic [BLOCKS-1:0] blk_mask, // Blocks to erase
	input wire logic prog_req, // User mode program request
	input wire logic [2:0] prog_blk, // Block to program
	output logic txd_r, // Serial channel 1 transmit
	output logic [DIV_W-1:0] baud_divisor_register_r, // Cycles per bit in use
	output logic rate_err_r, // Measured rate outside the valid window
	output logic erase_all_r, // Whole-array erase request
	output logic erase_blk_r, // Block erase request
	output logic [BLOCKS-1:0] erase_mask_r, // Blocks being erased
	output logic prog_go_r, // Program request accepted, one cycle
	output logic prog_refused_r, // Program request refused, one cycle
	output logic ram_we_r, // RAM write strobe
	output logic [19:0] ram_addr_r, // RAM write address
	output logic [7:0] ram_wdata_r, // RAM write data
	output logic jump_r, // Branch to loaded program, one cycle
	output logic [19:0] jump_addr_r, // Branch target
	output logic pe_enable_r // Flash program/erase enabled
);
	typedef enum logic [11:0] {
		ST_WAIT = 12'h001,
		ST_IDLE = 12'h002,
		ST_MEAS = 12'h004,
		ST_ADJ = 12'h008,
		ST_ADJW = 12'h010,
		ST_ACK = 12'h020,
		ST_ERASE = 12'h040,
		ST_LENH = 12'h080,
		ST_LENL = 12'h100,
		ST_LOAD = 12'h200,
		ST_RUN = 12'h400,
		ST_USER = 12'h800
	} sbl_state_e;

	sbl_state_e st_r, st_nxt;
	logic [MEAS_W-1:0] meas_r, meas_nxt;
	logic [15:0] len_r, len_nxt;
	logic [DIV_W-1:0] div_nxt;
	logic [BLOCKS-1:0] erased_r, erased_nxt, emask_nxt;
	logic [19:0] addr_nxt, jaddr_nxt;
	logic [7:0] wdata_nxt;
	logic rerr_nxt, eall_nxt, eblk_nxt, pgo_nxt, pref_nxt, we_nxt, jump_nxt, pe_nxt;
	logic uart_en, tx_go, tx_busy, rx_valid, rx_ferr, txd_u;
	logic [7:0] rx_data;
	logic [DIV_W-1:0] bit_est;
	logic [MEAS_W-1:0] bit_quot;

	function automatic logic rate_ok(input logic [DIV_W-1:0] cyc);
		rate_ok = (cyc >= BIT_CYC_MIN) && (cyc <= BIT_CYC_MAX);
	endfunction

	// A zero byte is low for start plus eight data bits
	assign bit_quot = meas_r / MEAS_W'(LOW_BITS);
	// A stuck-low line would wrap the divisor back into the valid window, so saturate instead
	assign bit_est = (bit_quot[MEAS_W-1:DIV_W] != '0) ? '1 : bit_quot[DIV_W-1:0];
	assign uart_en = !(st_r inside {ST_WAIT, ST_IDLE, ST_MEAS, ST_RUN, ST_USER});
	assign tx_go = (st_r == ST_ADJ);

	sbl_uart u_sbl_uart (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.en(uart_en),
		.bit_cyc(baud_divisor_register_r),
		.rxd(rxd),
		.txd_r(txd_u),
		.tx_go(tx_go),
		.tx_data(ADJ_DONE_BYTE),
		.tx_busy_r(tx_busy),
		.rx_valid_r(rx_valid),
		.rx_ferr_r(rx_ferr),
		.rx_data_r(rx_data)
	);

	always_comb begin
		st_nxt = st_r;
		meas_nxt = meas_r;
		len_nxt = len_r;
		div_nxt = baud_divisor_register_r;
		rerr_nxt = rate_err_r;
		eall_nxt = erase_all_r;
		eblk_nxt = erase_blk_r;
		emask_nxt = erase_mask_r;
		erased_nxt = erased_r;
		addr_nxt = ram_addr_r;
		wdata_nxt = ram_wdata_r;
		jaddr_nxt = jump_addr_r;
		pe_nxt = pe_enable_r;
		pgo_nxt = 1'b0;
		pref_nxt = 1'b0;
		we_nxt = 1'b0;
		jump_nxt = 1'b0;
		unique case (st_r)
			ST_WAIT: begin
				meas_nxt = meas_r + 1'b1;
				if (meas_r == MEAS_W'(WAIT_CYC - 1)) begin
					meas_nxt = '0;
					st_nxt = boot_strap ? ST_IDLE : ST_USER;
				end
			end
			ST_IDLE: begin
				if (!rxd) begin
					meas_nxt = MEAS_W'(1);
					st_nxt = ST_MEAS;
				end
			end
			ST_MEAS: begin
				if (!rxd) begin
					if (meas_r != '1) begin
						meas_nxt = meas_r + 1'b1;
					end
				end else begin
					div_nxt = bit_est;
					rerr_nxt = !rate_ok(bit_est);
					st_nxt = ST_ADJ;
				end
			end
			ST_ADJ: begin
				st_nxt = ST_ADJW; // Exactly one adjustment-done byte
			end
			ST_ADJW: begin
				if (!tx_busy) begin
					st_nxt = ST_ACK;
				end
			end
			ST_ACK: begin
				// Stray zeros from the host's stream are expected here and skipped
				if (rx_valid && rx_data == ACK_BYTE) begin
					eall_nxt = 1'b1;
					st_nxt = ST_ERASE;
				end else if (rx_ferr || (rx_valid && rx_data != ADJ_DONE_BYTE)) begin
					st_nxt = ST_IDLE; // Back to measurement; host retries with zeros, no reset
				end
			end
			ST_ERASE: begin
				if (flash_done) begin
					eall_nxt = 1'b0;
					erased_nxt = '1;
					st_nxt = ST_LENH;
				end
			end
			ST_LENH: begin
				if (rx_valid) begin
					len_nxt = {rx_data, 8'h00};
					st_nxt = ST_LENL;
				end
			end
			ST_LENL: begin
				if (rx_valid) begin
					len_nxt = {len_r[15:8], rx_data};
					addr_nxt = RAM_XFER_START - 20'h00001;
					st_nxt = ({len_r[15:8], rx_data} == 16'h0000) ? ST_RUN : ST_LOAD;
					jump_nxt = ({len_r[15:8], rx_data} == 16'h0000);
					pe_nxt = jump_nxt;
					jaddr_nxt = RAM_XFER_START;
				end
			end
			ST_LOAD: begin
				if (rx_valid) begin
					we_nxt = 1'b1;
					addr_nxt = ram_addr_r + 20'h00001;
					wdata_nxt = rx_data;
					len_nxt = len_r - 16'h0001;
					if (len_r == 16'h0001) begin
						st_nxt = ST_RUN;
					end
				end
			end
			ST_RUN: begin
				// The jump follows the last RAM write by one cycle
				if (ram_we_r && !pe_enable_r) begin
					jump_nxt = 1'b1;
					pe_nxt = 1'b1;
				end
			end
			ST_USER: begin
				// Both pin and software confirmation gate any change
				pe_nxt = flash_write_enable_pin && sw_pin_ok;
				if (erase_blk_r) begin
					if (flash_done) begin
						eblk_nxt = 1'b0;
						erased_nxt = erased_r | erase_mask_r;
					end
				end else if (pe_enable_r && blk_erase_req && blk_mask != '0) begin
					eblk_nxt = 1'b1; // Whole blocks only
					emask_nxt = blk_mask;
				end else if (prog_req) begin
					pgo_nxt = pe_enable_r && erased_r[prog_blk];
					pref_nxt = !(pe_enable_r && erased_r[prog_blk]);
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= ST_WAIT;
			meas_r <= '0;
			len_r <= '0;
			baud_divisor_register_r <= BIT_CYC_FAST;
			rate_err_r <= 1'b0;
			erase_all_r <= 1'b0;
			erase_blk_r <= 1'b0;
			erase_mask_r <= '0;
			erased_r <= '0;
			prog_go_r <= 1'b0;
			prog_refused_r <= 1'b0;
			ram_we_r <= 1'b0;
			ram_addr_r <= '0;
			ram_wdata_r <= ERASED_BYTE;
			jump_r <= 1'b0;
			jump_addr_r <= '0;
			pe_enable_r <= 1'b0;
			txd_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			meas_r <= meas_nxt;
			len_r <= len_nxt;
			baud_divisor_register_r <= div_nxt;
			rate_err_r <= rerr_nxt;
			erase_all_r <= eall_nxt;
			erase_blk_r <= eblk_nxt;
			erase_mask_r <= emask_nxt;
			erased_r <= erased_nxt;
			prog_go_r <= pgo_nxt;
			prog_refused_r <= pref_nxt;
			ram_we_r <= we_nxt;
			ram_addr_r <= addr_nxt;
			ram_wdata_r <= wdata_nxt;
			jump_r <= jump_nxt;
			jump_addr_r <= jaddr_nxt;
			pe_enable_r <= pe_nxt;
			txd_r <= txd_u;
		end
	end

	a_no_early_meas: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(resetn) |-> (st_r == ST_WAIT) [*4])
		else $error("measurement started too soon after reset");
	a_one_adj_byte: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_ADJ) |=> (st_r == ST_ADJW) ##1 (st_r != ST_ADJ) [*8])
		else $error("adjustment byte not sent exactly once");
	a_div_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_MEAS && rxd) |=> baud_divisor_register_r == $past(bit_est))
		else $error("baud divisor not taken from the measured low time");
	a_erase_first: assert property (@(posedge ref_clk) disable iff (!resetn)
		ram_we_r && boot_strap |-> erased_r == '1 && !erase_all_r)
		else $error("RAM load before full erase");
	a_erase_on_ack: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_ACK && rx_valid && rx_data == ACK_BYTE) |=> erase_all_r && st_r == ST_ERASE)
		else $error("acknowledge byte did not start erase");
	a_jump_target: assert property (@(posedge ref_clk) disable iff (!resetn)
		jump_r |-> jump_addr_r == RAM_XFER_START && pe_enable_r && st_r == ST_RUN)
		else $error("jump to wrong address or without program enable");
	a_jump_after_load: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_RUN && ram_we_r && !pe_enable_r) |=> jump_r ##1 !jump_r)
		else $error("jump missing after the last RAM write");
	a_uart_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_RUN || st_r == ST_USER) |=> txd_r)
		else $error("transmit line not idle outside the boot exchange");
	a_prog_erased: assert property (@(posedge ref_clk) disable iff (!resetn)
		prog_go_r |-> $past(erased_r[prog_blk]) && $past(pe_enable_r))
		else $error("program granted on an unerased block");
	a_blk_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(erase_blk_r) |-> $past(flash_write_enable_pin, 2) && $past(sw_pin_ok, 2))
		else $error("block erase without confirmed write enable");
	a_blk_whole: assert property (@(posedge ref_clk) disable iff (!resetn)
		erase_blk_r && flash_done |=> (erased_r & $past(erase_mask_r)) == $past(erase_mask_r))
		else $error("erased block not recorded");
	a_rate_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_ADJ) |-> rate_err_r == !rate_ok(baud_divisor_register_r))
		else $error("rate window flag wrong");
	a_erase_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		erase_all_r && !flash_done |=> erase_all_r)
		else $error("full erase request dropped before completion");
	a_ack_refused: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_ACK && rx_valid && rx_data != ACK_BYTE && rx_data != ADJ_DONE_BYTE)
		|=> st_r == ST_IDLE && !erase_all_r)
		else $error("wrong handshake byte not refused");
	a_blk_nonzero: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(erase_blk_r) |-> erase_mask_r != '0)
		else $error("block erase started with no block selected");
	a_user_pe: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_USER) |=> pe_enable_r == $past(flash_write_enable_pin && sw_pin_ok))
		else $error("program enable does not follow pin and confirmation");
	a_user_no_all: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ST_USER) |-> !erase_all_r)
		else $error("whole-array erase in user program mode");
endmodule

// ==== core/sbl_pkg.sv ====
// Constants shared by the serial boot loader and its serial line unit.
// Assumes one 25 MHz clock and a host that speaks 8N1 asynchronous serial.
// Notes on behaviour
// - Boot mode erases the whole flash array to all-ones before any new content is taken.
// - Boot mode talks to the host only through serial channel 1 in asynchronous mode.
// - The host streams zero bytes after reset and the loader times their low part to learn the bit period.
// - Every boot character is eight data bits, one stop bit and no parity.
// - The loader sets its baud divisor from the measured low time before program reception starts.
// - When the rate is set the loader sends exactly one zero byte as the adjustment-done mark.
// - Adjustment is only valid for 8-18 MHz at 9600 bit/s or 4-18 MHz at 4800 bit/s; this loader runs at 25 MHz and checks only BIT_CYC_MIN..BIT_CYC_MAX.
// - Once the program is in RAM the loader jumps to the RAM transfer start and enables flash program/erase.
// - User program mode erases whole blocks only, never single bytes, leaving all-ones.
// - User reprogramming starts only with the write enable pin high and that level confirmed by software.
// - Reset ends with the receive line high and the loader waits about 100 states before measuring.
package sbl_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int RATE_FAST = 9600;
	localparam int RATE_SLOW = 4800;
	localparam int CLK_MIN_FAST_HZ = 8_000_000;
	localparam int CLK_MIN_SLOW_HZ = 4_000_000;
	localparam int CLK_MAX_HZ = 18_000_000;
	localparam int START_WAIT_STATES = 100;
	localparam int DATA_BITS = 8;
	localparam int LOW_BITS = DATA_BITS + 1;
	localparam int DIV_W = 16;
	localparam int MEAS_W = 20;
	localparam logic [DIV_W-1:0] BIT_CYC_FAST = DIV_W'(CLK_HZ / RATE_FAST);
	localparam logic [DIV_W-1:0] BIT_CYC_SLOW = DIV_W'(CLK_HZ / RATE_SLOW);
	localparam logic [DIV_W-1:0] BIT_CYC_MIN = DIV_W'(CLK_HZ / RATE_FAST - CLK_HZ / RATE_FAST / 16);
	localparam logic [DIV_W-1:0] BIT_CYC_MAX = DIV_W'(CLK_HZ / RATE_SLOW + CLK_HZ / RATE_SLOW / 16);
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] ADJ_DONE_BYTE = 8'h00;
	localparam logic [7:0] ACK_BYTE = 8'h55;
	localparam logic [19:0] RAM_XFER_START = 20'hff300;
	localparam logic [19:0] EMU_WIN_LO = 20'hff800;
	localparam logic [19:0] EMU_WIN_HI = 20'hffbff;
	localparam int BLOCKS = 8;
endpackage

// ==== core/sbl_uart.sv ====
// Serial line unit for the boot loader: one 8N1 receiver and transmitter.
// Assumes rxd is already synchronous to ref_clk and bit_cyc stays still while en is high.
`timescale 1ns/1ps
module sbl_uart import sbl_pkg::*; (
	input wire logic ref_clk, // System clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic en, // Receiver and transmitter enable
	input wire logic [DIV_W-1:0] bit_cyc, // Clock cycles per bit
	input wire logic rxd, // Serial receive line
	output logic txd_r, // Serial transmit line
	input wire logic tx_go, // Start sending tx_data
	input wire logic [7:0] tx_data, // Byte to send
	output logic tx_busy_r, // Transmitter busy
	output logic rx_valid_r, // One-cycle pulse with a good byte
	output logic rx_ferr_r, // One-cycle pulse on a missing stop bit
	output logic [7:0] rx_data_r // Last received byte
);
	logic [DIV_W-1:0] rcnt_r, rcnt_nxt, tcnt_r, tcnt_nxt;
	logic [3:0] rbit_r, rbit_nxt, tbit_r, tbit_nxt;
	logic [7:0] rsh_r, rsh_nxt, rx_data_nxt;
	logic [9:0] tsh_r, tsh_nxt;
	logic rbusy_r, rbusy_nxt, rx_valid_nxt, rx_ferr_nxt, tx_busy_nxt, txd_nxt;

	always_comb begin
		rcnt_nxt = rcnt_r;
		rbit_nxt = rbit_r;
		rsh_nxt = rsh_r;
		rbusy_nxt = rbusy_r;
		rx_data_nxt = rx_data_r;
		rx_valid_nxt = 1'b0;
		rx_ferr_nxt = 1'b0;
		if (!en) begin
			rbusy_nxt = 1'b0;
		end else if (!rbusy_r) begin
			if (!rxd) begin
				rbusy_nxt = 1'b1;
				rbit_nxt = 4'h0;
				rcnt_nxt = bit_cyc >> 1; // First sample at mid start bit
			end
		end else if (rcnt_r != '0) begin
			rcnt_nxt = rcnt_r - 1'b1;
		end else begin
			rcnt_nxt = bit_cyc - 1'b1;
			rbit_nxt = rbit_r + 4'h1;
			if (rbit_r == 4'h0) begin
				rbusy_nxt = !rxd; // Glitch, not a start bit
			end else if (rbit_r <= 4'(DATA_BITS)) begin
				rsh_nxt = {rxd, rsh_r[7:1]}; // LSB first, no parity
			end else begin
				rbusy_nxt = 1'b0;
				rx_valid_nxt = rxd;
				rx_ferr_nxt = !rxd;
				if (rxd) begin
					rx_data_nxt = rsh_r;
				end
			end
		end
	end

	always_comb begin
		tcnt_nxt = tcnt_r;
		tbit_nxt = tbit_r;
		tsh_nxt = tsh_r;
		tx_busy_nxt = tx_busy_r;
		txd_nxt = txd_r;
		if (!en) begin
			tx_busy_nxt = 1'b0;
			txd_nxt = 1'b1;
		end else if (!tx_busy_r) begin
			txd_nxt = 1'b1;
			if (tx_go) begin
				tx_busy_nxt = 1'b1;
				tsh_nxt = {1'b1, tx_data, 1'b0}; // One stop bit
				tbit_nxt = 4'h0;
				tcnt_nxt = '0;
			end
		end else if (tcnt_r != '0) begin
			tcnt_nxt = tcnt_r - 1'b1;
		end else if (tbit_r == 4'(DATA_BITS + 2)) begin
			tx_busy_nxt = 1'b0;
		end else begin
			txd_nxt = tsh_r[0];
			tsh_nxt = {1'b1, tsh_r[9:1]};
			tbit_nxt = tbit_r + 4'h1;
			tcnt_nxt = bit_cyc - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rcnt_r <= '0;
			rbit_r <= '0;
			rsh_r <= '0;
			rbusy_r <= 1'b0;
			rx_data_r <= '0;
			rx_valid_r <= 1'b0;
			rx_ferr_r <= 1'b0;
			tcnt_r <= '0;
			tbit_r <= '0;
			tsh_r <= '1;
			tx_busy_r <= 1'b0;
			txd_r <= 1'b1;
		end else begin
			rcnt_r <= rcnt_nxt;
			rbit_r <= rbit_nxt;
			rsh_r <= rsh_nxt;
			rbusy_r <= rbusy_nxt;
			rx_data_r <= rx_data_nxt;
			rx_valid_r <= rx_valid_nxt;
			rx_ferr_r <= rx_ferr_nxt;
			tcnt_r <= tcnt_nxt;
			tbit_r <= tbit_nxt;
			tsh_r <= tsh_nxt;
			tx_busy_r <= tx_busy_nxt;
			txd_r <= txd_nxt;
		end
	end

	a_tx_start_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		$rose(tx_busy_r) |=> !txd_r)
		else $error("start bit missing");
	a_tx_stop_high: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(tx_busy_r) |-> txd_r)
		else $error("stop bit missing");
endmodule

// ==== testbench/sbl_host.sv ====
// Host side model for the boot loader: an 8N1 serial sender and receiver on the boot link.
// Assumes the loader's serial pins are synchronous to ref_clk and both lines are pulled up when idle.
`timescale 1ns/1ps
module sbl_host (
	input wire logic ref_clk, // System clock
	input wire logic txd, // Line from the loader
	output logic rxd // Line to the loader
);
	// Only the faster of the two legal host rates, to keep the run short
	localparam int BIT_CYC = 2604;
	logic got_start;

	initial begin
		rxd = 1'b1;
		got_start = 1'b0;
	end

	// Start bit, data LSB first, one stop bit, no parity; the stop bit leaves the line high
	task automatic send_byte(input logic [7:0] b, input int per);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= frame[i];
			repeat (per) @(posedge ref_clk);
		end
	endtask

	// Zeros keep coming until the loader starts its answer
	task automatic stream_zeros();
		got_start = 1'b0;
		while (!got_start)
			send_byte(8'h00, BIT_CYC);
	endtask

	// A low ok means the caller must reset the loader and start over
	task automatic recv_byte(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		b = 8'h00;
		while (txd !== 1'b0 && n < 40000) begin
			@(posedge ref_clk);
			n++;
		end
		got_start = 1'b1;
		repeat (BIT_CYC / 2) @(posedge ref_clk);
		ok = (txd === 1'b0) && (n < 40000);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge ref_clk);
			b[i] = txd;
		end
		repeat (BIT_CYC) @(posedge ref_clk);
		ok = ok && (txd === 1'b1);
	endtask
	// Images sent are one byte long at the transfer start, far from the emulation window
	// and the loader's own area
endmodule

// ==== testbench/test_serial_boot_loader_autobaud.sv ====
// Self-checking bench for the boot loader: reset, user mode guards, rate error and a full boot load.
// Assumes the loader's package and the host model; flash completion is pulsed by the bench.
`timescale 1ns/1ps
module test_serial_boot_loader_autobaud import sbl_pkg::*; ;
	localparam int WAIT_SIM = 4;
	logic ref_clk, resetn, boot_strap, flash_write_enable_pin, sw_pin_ok, rxd, flash_done;
	logic blk_erase_req, prog_req, txd_r, rate_err_r, erase_all_r, erase_blk_r;
	logic prog_go_r, prog_refused_r, ram_we_r, jump_r, pe_enable_r, txd_prev;
	logic [BLOCKS-1:0] blk_mask;
	logic [BLOCKS-1:0] erase_mask_r;
	logic [2:0] prog_blk;
	logic [DIV_W-1:0] baud_divisor_register_r;
	logic [19:0] ram_addr_r, jump_addr_r, last_addr;
	logic [7:0] ram_wdata_r, last_data;
	int miscompares, n_compared, tx_starts, writes, jumps, n;

	sbl_loader #(.WAIT_CYC(WAIT_SIM)) u_sbl_loader (.ref_clk(ref_clk), .resetn(resetn), .boot_strap(boot_strap),
		.flash_write_enable_pin(flash_write_enable_pin), .sw_pin_ok(sw_pin_ok), .rxd(rxd),
		.flash_done(flash_done), .blk_erase_req(blk_erase_req), .blk_mask(blk_mask), .prog_req(prog_req),
		.prog_blk(prog_blk), .txd_r(txd_r), .baud_divisor_register_r(baud_divisor_register_r),
		.rate_err_r(rate_err_r), .erase_all_r(erase_all_r), .erase_blk_r(erase_blk_r),
		.erase_mask_r(erase_mask_r), .prog_go_r(prog_go_r), .prog_refused_r(prog_refused_r),
		.ram_we_r(ram_we_r), .ram_addr_r(ram_addr_r), .ram_wdata_r(ram_wdata_r), .jump_r(jump_r),
		.jump_addr_r(jump_addr_r), .pe_enable_r(pe_enable_r));
	sbl_host u_sbl_host (.ref_clk(ref_clk), .txd(txd_r), .rxd(rxd));

	always #20 ref_clk = ~ref_clk;

	// Counts transmit starts, RAM writes and branches since the last reset
	always @(posedge ref_clk) begin
		txd_prev <= txd_r;
		if (!resetn) begin
			tx_starts <= 0;
			writes <= 0;
			jumps <= 0;
		end else begin
			if (txd_prev === 1'b1 && txd_r === 1'b0)
				tx_starts <= tx_starts + 1;
			if (ram_we_r === 1'b1) begin
				writes <= writes + 1;
				last_addr <= ram_addr_r;
				last_data <= ram_wdata_r;
			end
			if (jump_r === 1'b1)
				jumps <= jumps + 1;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic do_reset(input logic boot);
		resetn <= 1'b0;
		boot_strap <= boot;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		// Outputs are judged between edges, once the first edge after release has settled
		@(posedge ref_clk);
		@(negedge ref_clk);
		check("reset txd", txd_r, 1'b1);
		check("reset divisor", baud_divisor_register_r, BIT_CYC_FAST);
		check("reset jump", jump_r, 1'b0);
		check("reset erase", erase_all_r, 1'b0);
		check("reset pe_enable", pe_enable_r, 1'b0);
		repeat (WAIT_SIM + 1) @(posedge ref_clk);
	endtask

	task automatic prog_try(input logic [2:0] blk, input logic go);
		prog_req <= 1'b1;
		prog_blk <= blk;
		@(posedge ref_clk);
		prog_req <= 1'b0;
		@(negedge ref_clk);
		check("prog_go", prog_go_r, go);
		check("prog_refused", prog_refused_r, !go);
		@(posedge ref_clk);
	endtask

	task automatic test_user();
		do_reset(1'b0);
		// The pin alone, without the software confirmation, must not open the flash
		flash_write_enable_pin <= 1'b1;
		blk_mask <= 8'h04;
		blk_erase_req <= 1'b1;
		repeat (3) @(posedge ref_clk);
		blk_erase_req <= 1'b0;
		@(negedge ref_clk);
		check("erase_blk without confirm", erase_blk_r, 1'b0);
		check("pe_enable without confirm", pe_enable_r, 1'b0);
		@(posedge ref_clk);
		sw_pin_ok <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		check("pe_enable", pe_enable_r, 1'b1);
		@(posedge ref_clk);
		prog_try(3'h2, 1'b0);
		blk_mask <= 8'h00;
		blk_erase_req <= 1'b1;
		@(posedge ref_clk);
		blk_erase_req <= 1'b0;
		@(negedge ref_clk);
		check("erase_blk empty mask", erase_blk_r, 1'b0);
		@(posedge ref_clk);
		blk_mask <= 8'h04;
		blk_erase_req <= 1'b1;
		@(posedge ref_clk);
		blk_erase_req <= 1'b0;
		@(negedge ref_clk);
		check("erase_blk", erase_blk_r, 1'b1);
		check("erase_mask", erase_mask_r, 8'h04);
		@(posedge ref_clk);
		flash_done <= 1'b1;
		@(posedge ref_clk);
		flash_done <= 1'b0;
		@(negedge ref_clk);
		check("erase_blk done", erase_blk_r, 1'b0);
		@(posedge ref_clk);
		// Two requests back to back: erased block, then one never erased
		prog_req <= 1'b1;
		prog_blk <= 3'h2;
		@(posedge ref_clk);
		prog_blk <= 3'h3;
		@(negedge ref_clk);
		check("prog_go erased", prog_go_r, 1'b1);
		@(posedge ref_clk);
		prog_req <= 1'b0;
		@(negedge ref_clk);
		check("prog_go unerased", prog_go_r, 1'b0);
		check("prog_refused unerased", prog_refused_r, 1'b1);
		@(posedge ref_clk);
		flash_write_enable_pin <= 1'b0;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		check("pe_enable off", pe_enable_r, 1'b0);
		@(posedge ref_clk);
		prog_try(3'h2, 1'b0);
		sw_pin_ok <= 1'b0;
	endtask

	task automatic test_rate_err();
		do_reset(1'b1);
		u_sbl_host.send_byte(8'h00, 200);
		repeat (5) @(posedge ref_clk);
		check("rate_err short", rate_err_r, 1'b1);
		check("divisor short", baud_divisor_register_r, 16'h00c8);
		// The adjustment byte still goes out at the measured rate; a wrong reply forces a new measurement
		repeat (2000) @(posedge ref_clk);
		check("tx bytes short", tx_starts, 1);
		u_sbl_host.send_byte(8'haa, 200);
		check("erase after bad reply", erase_all_r, 1'b0);
		u_sbl_host.send_byte(8'h00, 200);
		repeat (5) @(posedge ref_clk);
		check("tx bytes remeasured", tx_starts, 2);
	endtask

	task automatic test_boot();
		logic [7:0] b;
		logic ok;
		do_reset(1'b1);
		fork
			u_sbl_host.stream_zeros();
			u_sbl_host.recv_byte(b, ok);
		join
		check("divisor", baud_divisor_register_r, BIT_CYC_FAST);
		check("rate_err", rate_err_r, 1'b0);
		check("adjust byte", b, ADJ_DONE_BYTE);
		check("adjust frame", ok, 1'b1);
		check("erase before ack", erase_all_r, 1'b0);
		u_sbl_host.send_byte(ACK_BYTE, 2604);
		for (n = 0; n < 200 && erase_all_r !== 1'b1; n++) @(posedge ref_clk);
		check("erase_all", erase_all_r, 1'b1);
		flash_done <= 1'b1;
		@(posedge ref_clk);
		flash_done <= 1'b0;
		for (n = 0; n < 10 && erase_all_r !== 1'b0; n++) @(posedge ref_clk);
		check("erase_all done", erase_all_r, 1'b0);
		check("writes before load", writes, 0);
		u_sbl_host.send_byte(8'h00, 2604);
		u_sbl_host.send_byte(8'h01, 2604);
		u_sbl_host.send_byte(8'ha5, 2604);
		for (n = 0; n < 200 && jumps == 0; n++) @(posedge ref_clk);
		check("writes", writes, 1);
		check("write addr", last_addr, RAM_XFER_START);
		check("write data", last_data, 8'ha5);
		check("jumps", jumps, 1);
		check("jump addr", jump_addr_r, RAM_XFER_START);
		check("pe_enable", pe_enable_r, 1'b1);
		check("tx bytes", tx_starts, 1);
	endtask

	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		boot_strap = 1'b1;
		flash_write_enable_pin = 1'b0;
		sw_pin_ok = 1'b0;
		flash_done = 1'b0;
		blk_erase_req = 1'b0;
		blk_mask = 8'h00;
		prog_req = 1'b0;
		prog_blk = 3'h0;
		miscompares = 0;
		n_compared = 0;
		test_user();
		test_rate_err();
		test_boot();
		end_of_test();
	end

	// Six frames at 9600 bit/s make the boot load about 156k cycles; a hang is cut soon after
	initial begin
		repeat (220000) @(posedge ref_clk);
		miscompares++;
		$display("[FAIL] watchdog expected finish seen timeout");
		end_of_test();
	end
endmodule
